// *** rtl/waec_pkg.sv ***
/*
 * Package for the waveform average and extrema accumulator: register map,
 * field positions, reset values, timing counts, modes and carrier structs.
 * Assumes a 125 MHz system clock and an AXI4-Lite register bus.
 */
package waec_pkg;

  // Clock and display pacing
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned DISP_PERIOD_MS  = 1500;
  localparam int unsigned DISP_CYCLES     = (CLK_HZ / 1000) * DISP_PERIOD_MS;

  // Record geometry
  localparam int unsigned SAMPLE_W        = 16;
  localparam int unsigned REC_LEN         = 256;
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned ACC_W           = 40;
  localparam int unsigned CNT_W           = 20;
  localparam int unsigned WGT_W           = 8;

  // Record limits
  localparam logic [CNT_W-1:0] LIMIT_BASIC    = 20'h003E8;
  localparam logic [CNT_W-1:0] LIMIT_EXTENDED = 20'hF4240;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_MAXCNT  = 8'h04;
  localparam logic [7:0] OFS_WEIGHT  = 8'h08;
  localparam logic [7:0] OFS_SEGSEL  = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_COUNT   = 8'h14;

  // Control fields
  localparam int unsigned CTRL_MODE_LO  = 0;
  localparam int unsigned CTRL_EXT_SEL  = 2;
  localparam int unsigned CTRL_SEG_EN   = 4;
  localparam int unsigned CTRL_EXTOPT   = 5;
  localparam int unsigned CTRL_CLEAR    = 8;

  // Status fields
  localparam int unsigned STAT_DONE     = 0;
  localparam int unsigned STAT_PAUSED   = 1;

  // Reset values
  localparam logic [CNT_W-1:0] MAXCNT_RST = 20'h003E8;
  localparam logic [WGT_W-1:0] WEIGHT_RST = 8'h03;

  typedef enum logic [1:0] {
    WAEC_MODE_SUMMED,
    WAEC_MODE_CONT,
    WAEC_MODE_EXTREMA,
    WAEC_MODE_OFF
  } waec_mode_e;

  typedef enum logic [1:0] {
    WAEC_EXT_ROOF,
    WAEC_EXT_FLOOR,
    WAEC_EXT_BOTH,
    WAEC_EXT_RSVD
  } waec_ext_e;

  typedef struct packed {
    logic                  valid;
    logic                  last;
    logic [ADDR_W-1:0]     index;
    logic signed [SAMPLE_W-1:0] data;
  } waec_sample_s;

  typedef struct packed {
    logic                  valid;
    logic [ADDR_W-1:0]     index;
    logic signed [SAMPLE_W-1:0] primary;
    logic signed [SAMPLE_W-1:0] secondary;
  } waec_out_s;

endpackage : waec_pkg

// *** rtl/waec_top.sv ***
/*
 * Waveform average and extrema accumulator. Takes sample records from the
 * acquisition memory and folds them into summed, continuous or extrema
 * results; results stream out on a display pass.
 * Assumes records arrive one at a time, samples in index order, with last on
 * the final sample, and a one-cycle pulse on any acquisition setting change.
 */
// Operation
// - Summed mode adds records with equal weight
// - Limit 1000 basic, 1000000 with option
// - Summed stops and holds at maximum
// - Raising maximum continues; other change restarts
// - Summed pauses when stopped or trace off
// - Clear or parameter change clears summed
// - Summed record count readable
// - Summed output to display every 1.5s
// - Summed accepts segments, all or one
// - Continuous decay slows as weight rises
// - Continuous: new weight 1, old weight n
// - Extrema replaces roof above, floor below
// - Extrema output roof, floor or both
// - Extrema stops and holds at maximum
// - Extrema pauses when stopped or trace off
// - Clear or parameter change resets extrema
// - Raising extrema maximum continues; others restart
// - Extrema record count readable
// - Summed uses first n records only
module waec_top (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire waec_pkg::waec_sample_s      sample_i,
  input  wire logic [7:0]                  seg_index_i,
  input  wire logic                        param_change_i,
  input  wire logic                        repetitive_trigger_mode_i,
  input  wire logic                        trace_on_i,
  output waec_pkg::waec_out_s              disp_o,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);

  localparam int unsigned AW = waec_pkg::ADDR_W;
  localparam int unsigned SW = waec_pkg::SAMPLE_W;
  localparam int unsigned CW = waec_pkg::CNT_W;

  // Result memories, one word per sample position
  logic signed [waec_pkg::ACC_W-1:0] acc_mem   [waec_pkg::REC_LEN];
  logic signed [SW-1:0]              roof_mem  [waec_pkg::REC_LEN];
  logic signed [SW-1:0]              floor_mem [waec_pkg::REC_LEN];

  // Software registers
  waec_pkg::waec_mode_e  mode;
  waec_pkg::waec_ext_e   ext_sel;
  logic                  seg_en;
  logic                  ext_opt;
  logic [CW-1:0]         max_cnt;
  logic [waec_pkg::WGT_W-1:0] weight;
  logic [7:0]            seg_sel;
  logic [CW-1:0]         count;
  logic                  in_record;
  logic                  restart;
  logic                  sw_clear;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic [CW-1:0] wr_max;
  logic [CW-1:0] wr_lim;

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Latch channels independently; ready is high only while the slot is empty
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr <= waec_pkg::OFS_SEGSEL && aw_addr[1:0] == 2'h0) ?
                        2'h0 : 2'h2; // Unmapped or read-only gives SLVERR
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Limit the written maximum to what the fitted option allows
  assign wr_lim = ext_opt ? waec_pkg::LIMIT_EXTENDED : waec_pkg::LIMIT_BASIC;
  assign wr_max = (w_data[CW-1:0] > wr_lim) ? wr_lim : w_data[CW-1:0];

  // Register writes; any setting other than a raised or unchanged maximum forces restart
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode     <= waec_pkg::WAEC_MODE_OFF;
      ext_sel  <= waec_pkg::WAEC_EXT_BOTH;
      seg_en   <= 1'b0;
      ext_opt  <= 1'b0;
      max_cnt  <= waec_pkg::MAXCNT_RST;
      weight   <= waec_pkg::WEIGHT_RST;
      seg_sel  <= 8'h00;
      restart  <= 1'b0;
      sw_clear <= 1'b0;
    end else begin
      restart  <= 1'b0;
      sw_clear <= 1'b0;
      if (do_write && w_strb[0]) begin
        unique case (aw_addr)
          waec_pkg::OFS_CTRL: begin
            if (w_data[waec_pkg::CTRL_CLEAR]) begin
              sw_clear <= 1'b1;
            end else begin
              mode    <= waec_pkg::waec_mode_e'(w_data[waec_pkg::CTRL_MODE_LO +: 2]);
              ext_sel <= waec_pkg::waec_ext_e'(w_data[waec_pkg::CTRL_EXT_SEL +: 2]);
              seg_en  <= w_data[waec_pkg::CTRL_SEG_EN];
              ext_opt <= w_data[waec_pkg::CTRL_EXTOPT];
              restart <= 1'b1;
            end
          end
          waec_pkg::OFS_MAXCNT: begin
            max_cnt <= wr_max;
            restart <= (wr_max < max_cnt);
          end
          waec_pkg::OFS_WEIGHT: begin
            weight  <= w_data[waec_pkg::WGT_W-1:0];
            restart <= 1'b1;
          end
          waec_pkg::OFS_SEGSEL: begin
            seg_sel <= w_data[7:0];
            restart <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path: one cycle from address to data
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h00000000;
    unique case (s_axi_araddr)
      waec_pkg::OFS_CTRL:   rd_word = {26'h0000000, ext_opt, seg_en, ext_sel, mode};
      waec_pkg::OFS_MAXCNT: rd_word = {12'h000, max_cnt};
      waec_pkg::OFS_WEIGHT: rd_word = {24'h000000, weight};
      waec_pkg::OFS_SEGSEL: rd_word = {24'h000000, seg_sel};
      waec_pkg::OFS_STATUS: rd_word = {30'h00000000,
                                       !(repetitive_trigger_mode_i && trace_on_i),
                                       count >= max_cnt};
      waec_pkg::OFS_COUNT:  rd_word = {12'h000, count};
      default:              rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (s_axi_araddr <= waec_pkg::OFS_COUNT &&
                         s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Record acceptance: a record is taken whole or not at all
  logic wipe;
  logic can_take;
  logic take;
  logic seg_match;

  assign wipe      = sw_clear || param_change_i || restart;
  assign seg_match = !seg_en || seg_index_i == seg_sel;
  // Pausing only blocks new records; stored results stay untouched
  assign can_take  = repetitive_trigger_mode_i && trace_on_i && seg_match &&
                     (mode == waec_pkg::WAEC_MODE_CONT || count < max_cnt);
  assign take      = sample_i.valid && (in_record || (sample_i.index == '0 && can_take));

  // Track whether the record in flight was admitted at its first sample
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_record <= 1'b0;
    end else if (wipe) begin
      in_record <= 1'b0;
    end else if (take) begin
      in_record <= !sample_i.last;
    end
  end

  // Record count; one per admitted record outside off mode, held at all ones
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (wipe) begin
      count <= '0;
    end else if (take && sample_i.last && mode != waec_pkg::WAEC_MODE_OFF) begin
      if (count != {CW{1'b1}}) begin
        count <= count + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample arithmetic
  logic signed [waec_pkg::ACC_W-1:0] acc_old;
  logic signed [waec_pkg::ACC_W-1:0] cont_new;
  logic signed [SW-1:0]              roof_old;
  logic signed [SW-1:0]              floor_old;
  logic                              first_rec;
  logic [AW-1:0]                     idx;

  assign idx       = sample_i.index;
  assign acc_old   = acc_mem[idx];
  assign roof_old  = roof_mem[idx];
  assign floor_old = floor_mem[idx];
  assign first_rec = (count == '0);
  // Weighted mean: new + n*old, divided by n+1; larger n decays slower
  assign cont_new  = first_rec ? waec_pkg::ACC_W'(sample_i.data) :
                     waec_pkg::ACC_W'((waec_pkg::ACC_W'(sample_i.data) +
                      acc_old * $signed({1'b0, weight})) /
                      $signed({2'b00, weight} + 10'h001));

  // Per-position update; memories are not zeroed, the first record overwrites
  always_ff @(posedge clk_i) begin
    if (take && !wipe) begin
      unique case (mode)
        waec_pkg::WAEC_MODE_SUMMED: begin
          acc_mem[idx] <= first_rec ? waec_pkg::ACC_W'(sample_i.data) :
                          acc_old + waec_pkg::ACC_W'(sample_i.data);
        end
        waec_pkg::WAEC_MODE_CONT: acc_mem[idx] <= cont_new;
        waec_pkg::WAEC_MODE_EXTREMA: begin
          if (first_rec || sample_i.data > roof_old) begin
            roof_mem[idx] <= sample_i.data;
          end
          if (first_rec || sample_i.data < floor_old) begin
            floor_mem[idx] <= sample_i.data;
          end
        end
        waec_pkg::WAEC_MODE_OFF: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display pass: summed results only every 1.5 s, others after each record
  logic [31:0]   pace_cnt;
  logic          pace_tick;
  logic          disp_run;
  logic          disp_pend;
  logic [AW-1:0] disp_idx;
  logic signed [waec_pkg::ACC_W-1:0] avg_val;

  assign pace_tick = (pace_cnt == 32'(waec_pkg::DISP_CYCLES - 1));

  // Slow pacing trades display freshness for accumulation throughput
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pace_cnt <= 32'h00000000;
    end else if (pace_tick) begin
      pace_cnt <= 32'h00000000;
    end else begin
      pace_cnt <= pace_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      disp_pend <= 1'b0;
      disp_run  <= 1'b0;
      disp_idx  <= '0;
    end else begin
      if (mode == waec_pkg::WAEC_MODE_SUMMED ? pace_tick : (take && sample_i.last)) begin
        disp_pend <= (count != '0) || (take && sample_i.last);
      end
      if (!disp_run && disp_pend && !in_record) begin
        disp_run  <= 1'b1;
        disp_pend <= 1'b0;
        disp_idx  <= '0;
      end else if (disp_run) begin
        disp_idx <= disp_idx + 1'b1;
        if (disp_idx == AW'(waec_pkg::REC_LEN - 1)) begin
          disp_run <= 1'b0;
        end
      end
    end
  end

  assign avg_val = (count == '0) ? '0 :
                   acc_mem[disp_idx] / $signed({1'b0, count});

  // Output carrier registered straight from the pass
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      disp_o <= '0;
    end else begin
      disp_o.valid <= disp_run && mode != waec_pkg::WAEC_MODE_OFF;
      disp_o.index <= disp_idx;
      disp_o.secondary <= (mode == waec_pkg::WAEC_MODE_EXTREMA &&
                           ext_sel == waec_pkg::WAEC_EXT_BOTH) ?
                          floor_mem[disp_idx] : '0;
      unique case (mode)
        waec_pkg::WAEC_MODE_SUMMED:  disp_o.primary <= SW'(avg_val);
        waec_pkg::WAEC_MODE_CONT:    disp_o.primary <= SW'(acc_mem[disp_idx]);
        waec_pkg::WAEC_MODE_EXTREMA: begin
          disp_o.primary <= (ext_sel == waec_pkg::WAEC_EXT_FLOOR) ?
                            floor_mem[disp_idx] : roof_mem[disp_idx];
        end
        waec_pkg::WAEC_MODE_OFF:     disp_o.primary <= '0;
      endcase
    end
  end

endmodule : waec_top

// *** tb/waec_acq_model.sv ***
/*
 * Acquisition memory model: plays one 256-sample record of a constant level
 * for each go pulse. Assumes go_i is a one-cycle pulse given while busy_o is low.
 */
module waec_acq_model (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              go_i,
  input  wire logic [15:0]       level_i,
  output waec_pkg::waec_sample_s sample_o,
  output logic                   busy_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0]  pos;
  logic [15:0] level;
  logic [15:0] idle_pat;

  // One whole record per request, samples in index order
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'h0;
      pos <= 8'h00;
      level <= 16'h0000;
    end else if (go_i && !busy_o) begin
      busy_o <= 1'h1;
      pos <= 8'h00;
      level <= level_i;
    end else if (busy_o) begin
      pos <= pos + 8'h01;
      busy_o <= (pos != 8'hFF);
    end
  end

  // Idle data keeps moving so a stale sample is never mistaken for a live one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) idle_pat <= 16'h5A5A;
    else idle_pat <= ~idle_pat;
  end

  // Sample bus, last marks index 255
  always_comb begin
    sample_o.valid = busy_o;
    sample_o.last = busy_o && (pos == 8'hFF);
    sample_o.index = pos;
    sample_o.data = busy_o ? level : idle_pat;
  end
endmodule : waec_acq_model

// *** tb/waec_properties.sv ***
/*
 * Checker for waec_top: display pass shape and register bus answers.
 * Bound to waec_top below; sees only its ports.
 */
module waec_properties (
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire waec_pkg::waec_out_s disp_o,
  input wire logic [7:0]          s_axi_awaddr,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [7:0]          s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic aw_bad;
  logic ar_bad;

  // Remember whether the address in flight must be refused
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_bad <= 1'h0;
      ar_bad <= 1'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready)
        aw_bad <= (s_axi_awaddr[1:0] != 2'h0) || (s_axi_awaddr >= 8'h10);
      if (s_axi_arvalid && s_axi_arready)
        ar_bad <= (s_axi_araddr[1:0] != 2'h0) || (s_axi_araddr > 8'h14);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence aw_take;
    s_axi_awvalid && s_axi_awready;
  endsequence

  disp_open_a: assert property (
    $rose(disp_o.valid) |-> disp_o.index == 8'h00) else $error("display pass skips index 0");
  disp_step_a: assert property (
    disp_o.valid && disp_o.index != 8'hFF |=> disp_o.valid && disp_o.index ==
    $past(disp_o.index) + 8'h01) else $error("display pass breaks index order");
  rd_answer_a: assert property (
    ar_take |=> s_axi_rvalid) else $error("read answer late");
  aw_slot_a: assert property (
    aw_take |=> !s_axi_awready) else $error("write slot not closed");
  rd_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wr_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_refuse_a: assert property (
    s_axi_rvalid && ar_bad |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("bad read address not refused");
  wr_refuse_a: assert property (
    s_axi_bvalid && aw_bad |-> s_axi_bresp == 2'h2) else $error("read-only write accepted");
  rd_ok_a: assert property (
    s_axi_rvalid && !ar_bad |-> s_axi_rresp == 2'h0) else $error("good read refused");
endmodule : waec_properties

bind waec_top waec_properties u_waec_properties (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .disp_o(disp_o),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** tb/testbench.sv ***
/*
 * Testbench for waec_top: register tasks over AXI4-Lite, records from
 * waec_acq_model, display probe. Assumes a 125 MHz clock.
 */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk_i, rst_n_i, param_change_i, trig, trace, go, busy;
  logic                   awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic [7:0]             seg, awa, ara;
  logic [15:0]            lvl;
  logic [31:0]            wd, rdd;
  logic [1:0]             bresp, rresp;
  waec_pkg::waec_sample_s smp;
  waec_pkg::waec_out_s    disp;
  int                     fails, checked;

  waec_top u_waec_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .sample_i(smp), .seg_index_i(seg),
    .param_change_i(param_change_i), .repetitive_trigger_mode_i(trig), .trace_on_i(trace),
    .disp_o(disp), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr));
  waec_acq_model u_waec_acq_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go),
    .level_i(lvl), .sample_o(smp), .busy_o(busy));

  // 8 ns clock
  initial clk_i = 1'h0;
  always #4 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together, each dropped once taken
  task wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    @(posedge clk_i);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk_i);
      if (awv && awr) awv <= 1'h0;
      if (wv && wr_r) wv <= 1'h0;
      if (bv && br) break;
    end
    br <= 1'h0;
    chk({31'h0, n == 200}, 32'h0);
    chk({30'h0, bresp}, {30'h0, r});
  endtask : wreg

  task rreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    int n;
    @(posedge clk_i);
    ara <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk_i);
      if (arv && arr) arv <= 1'h0;
      if (rv && rr) break;
    end
    rr <= 1'h0;
    chk({31'h0, n == 200}, 32'h0);
    chk(rdd, e);
    chk({30'h0, rresp}, {30'h0, r});
  endtask : rreg

  // One record; returns at the edge after its last sample
  task rec(input logic [15:0] v);
    int n;
    @(posedge clk_i);
    lvl <= v;
    go <= 1'h1;
    @(posedge clk_i);
    go <= 1'h0;
    for (n = 0; n < 400; n++) begin
      @(posedge clk_i);
      if (!busy) break;
    end
    chk({31'h0, n == 400}, 32'h0);
  endtask : rec

  // First sample of the next display pass
  task see(input logic [15:0] p, input logic [15:0] s, input bit two);
    int n;
    for (n = 0; n < 800; n++) begin
      @(posedge clk_i);
      if (disp.valid === 1'h1 && disp.index === 8'h00) break;
    end
    chk({31'h0, n == 800}, 32'h0);
    chk({16'h0, disp.primary}, {16'h0, p});
    if (two) chk({16'h0, disp.secondary}, {16'h0, s});
  endtask : see

  task finish_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int k;
    {rst_n_i, go, param_change_i, awv, wv, br, arv, rr} = 8'h00;
    {trig, trace} = 2'h3;
    {seg, awa, ara, lvl, wd} = 72'h0;
    fails = 0;
    checked = 0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'h1;
    rreg(8'h04, 32'h3E8);
    rreg(8'h08, 32'h3);
    rreg(8'h18, 32'h0, 2'h2);
    wreg(8'h14, 32'h5, 2'h2);
    wreg(8'h04, 32'hFFFFF);
    rreg(8'h04, 32'h3E8);
    wreg(8'h00, 32'h20);
    wreg(8'h04, 32'hFFFFF);
    rreg(8'h04, 32'hF4240);
    $display("test limits done");
    wreg(8'h00, 32'h0);
    wreg(8'h04, 32'h2);
    repeat (3) rec(16'h0010);
    rreg(8'h14, 32'h2);
    rreg(8'h10, 32'h1);
    wreg(8'h04, 32'h5);
    rec(16'h0010);
    rreg(8'h14, 32'h3);
    trig <= 1'h0;
    rec(16'h0010);
    rreg(8'h10, 32'h2);
    trig <= 1'h1;
    trace <= 1'h0;
    rec(16'h0010);
    rreg(8'h14, 32'h3);
    trace <= 1'h1;
    rec(16'h0010);
    rreg(8'h14, 32'h4);
    @(posedge clk_i);
    param_change_i <= 1'h1;
    @(posedge clk_i);
    param_change_i <= 1'h0;
    rreg(8'h14, 32'h0);
    rec(16'h0010);
    wreg(8'h00, 32'h100);
    rreg(8'h14, 32'h0);
    rec(16'h0010);
    wreg(8'h08, 32'h5);
    rreg(8'h14, 32'h0);
    wreg(8'h00, 32'h10);
    wreg(8'h0C, 32'h1);
    rec(16'h0010);
    rreg(8'h14, 32'h0);
    seg <= 8'h01;
    rec(16'h0010);
    rreg(8'h14, 32'h1);
    $display("test summed done");
    wreg(8'h00, 32'h0A);
    wreg(8'h04, 32'h2);
    rec(16'h000A);
    see(16'h000A, 16'h000A, 1'b1);
    rec(16'h0005);
    see(16'h000A, 16'h0005, 1'b1);
    rec(16'h0014);
    rreg(8'h14, 32'h2);
    wreg(8'h04, 32'h3);
    rec(16'h0014);
    see(16'h0014, 16'h0005, 1'b1);
    rreg(8'h14, 32'h3);
    for (k = 0; k < 2; k++) begin
      wreg(8'h00, k ? 32'h06 : 32'h02);
      rec(16'h0007);
      see(16'h0007, 16'h0, 1'b0);
      rec(16'h0003);
      see(k ? 16'h0003 : 16'h0007, 16'h0, 1'b0);
    end
    $display("test extrema done");
    for (k = 1; k < 4; k += 2) begin
      wreg(8'h00, 32'h1);
      wreg(8'h08, k);
      rec(16'h0064);
      see(16'h0064, 16'h0, 1'b0);
      rec(16'h01F4);
      see(16'((500 + k * 100) / (k + 1)), 16'h0, 1'b0);
    end
    $display("test continuous done");
    finish_test();
  end

  // Watchdog: the sequence needs about 6200 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
endmodule : testbench
